// ===== design/mif_defines.vh
`ifndef MIF_DEFINES_VH
`define MIF_DEFINES_VH

// register indices as printed, byte address is four times the index
`define MIF_IDX_ENABLE 8'h18
`define MIF_IDX_FLAGS 8'h19
`define MIF_IDX_FLAGS_COR 8'h1A
`define MIF_ADDR_ENABLE 8'h60
`define MIF_ADDR_FLAGS 8'h64
`define MIF_ADDR_FLAGS_COR 8'h68

// register widths and reset values
`define MIF_NUM_FLAGS 20
`define MIF_ENABLE_RESET 20'h00000
`define MIF_FLAGS_RESET 20'h00000
`define MIF_ENABLE_WMASK 20'hFDFFF

// flag bit positions
`define MIF_BIT_ACT_HALF 0
`define MIF_BIT_REACT_HALF 1
`define MIF_BIT_APP_HALF 2
`define MIF_BIT_SAG_A 3
`define MIF_BIT_TMO_A 6
`define MIF_BIT_CROSS_A 9
`define MIF_BIT_LINE_DONE 12
`define MIF_BIT_RESET_EVT 13
`define MIF_BIT_PEAK_V 14
`define MIF_BIT_PEAK_I 15
`define MIF_BIT_WAVE 16
`define MIF_BIT_ACT_SIGN 17
`define MIF_BIT_REACT_SIGN 18
`define MIF_BIT_SEQ_ERR 19

// axi responses
`define MIF_RESP_OKAY 2'h0
`define MIF_RESP_SLVERR 2'h2

`endif

// ===== design/mif_irq.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mif_defines.vh"
// What this block does
// - request line driven low while any enabled flag is set.
// - reading the clear-on-read flag register releases the request line.
// - every event sets its flag; the line is driven only if enabled.
// - flags other than bit 13 stay set until cleared, even after the event condition ends.
// - clear-on-read register returns flags, then clears to default every flag with no new event that cycle.
// - bit 0 flags a change of bit 14 in any active energy accumulator.
// - bit 1 flags a change of bit 14 in any reactive energy accumulator.
// - bit 2 flags a 0-to-1 step of bit 15 in any apparent accumulator.
// - bits 3 to 5 flag a voltage sag on phases a, b, c.
// - bits 6 to 8 flag a missing zero crossing on phases a, b, c.
// - bits 9 to 11 flag a voltage zero crossing on phases a, b, c.
// - bit 12 flags end of line-cycle energy accumulation.
// - bit 14 flags selected voltage above peak voltage level.
// - bit 15 flags selected current above peak current level.
// - bit 16 flags a new waveform sample ready for the host.
// - bit 17 flags active power sign change in a selected phase.
// - bit 18 flags reactive power sign change in a selected phase.
// - bit 19 flags crossing on phase a followed by b instead of c.
// - bit 13 reads as one for exactly one clock after reset.
module mif_irq #(
    parameter NUM_FLAGS = `MIF_NUM_FLAGS
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // accumulator top bits, per phase a, b, c
    input wire [2:0] active_energy_accum_b14_i,
    input wire [2:0] reactive_energy_accum_b14_i,
    input wire [2:0] apparent_energy_accum_b15_i,
    // line monitor event pulses, per phase a, b, c
    input wire [2:0] sag_i,
    input wire [2:0] crossing_timeout_i,
    input wire [2:0] crossing_i,
    // single event pulses
    input wire line_cycle_energy_done_i,
    input wire peak_voltage_i,
    input wire peak_current_i,
    input wire waveform_sample_ready_i,
    // power signs per phase and the phase-sum selection
    input wire [2:0] active_power_neg_i,
    input wire [2:0] reactive_power_neg_i,
    input wire [2:0] phase_sum_select_i,
    // open-drain request line
    output wire irq_n_o,
    output wire irq_oe_o,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // sequence checker states
    localparam [1:0] SEQ_IDLE = 2'b01;
    localparam [1:0] SEQ_AFTER_A = 2'b10;

    // flag and enable state
    reg [NUM_FLAGS-1:0] enable_q;
    reg [NUM_FLAGS-1:0] enable_d;
    reg [NUM_FLAGS-1:0] flags_q;
    reg [NUM_FLAGS-1:0] flags_d;
    reg [NUM_FLAGS-1:0] event_set;
    reg [NUM_FLAGS-1:0] reset_evt_vec;
    reg reset_evt_q;
    reg irq_oe_q;

    // history of the watched levels
    reg hist_valid_q;
    reg [2:0] act_b14_q;
    reg [2:0] react_b14_q;
    reg [2:0] app_b15_q;
    reg [2:0] act_neg_q;
    reg [2:0] react_neg_q;

    // sequence checker state
    reg [1:0] seq_q;
    reg [1:0] seq_d;
    reg seq_err;

    // per-phase event terms and the flag view
    wire [2:0] act_change;
    wire [2:0] react_change;
    wire [2:0] app_rise;
    wire [2:0] act_sign_change;
    wire [2:0] react_sign_change;
    wire [NUM_FLAGS-1:0] flags_view;

    // bus state
    reg [7:0] awaddr_q;
    reg aw_got_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_got_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // bus decode
    wire do_write;
    wire do_read;
    wire read_cor;
    wire [7:0] wr_idx;
    wire [7:0] rd_idx;
    wire [NUM_FLAGS-1:0] wr_bytes;

    // per-phase change detectors on accumulator bits and power signs
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
            assign act_change[ph] = hist_valid_q &
                (active_energy_accum_b14_i[ph] ^ act_b14_q[ph]);
            assign react_change[ph] = hist_valid_q &
                (reactive_energy_accum_b14_i[ph] ^ react_b14_q[ph]);
            assign app_rise[ph] = hist_valid_q &
                apparent_energy_accum_b15_i[ph] & ~app_b15_q[ph];
            assign act_sign_change[ph] = hist_valid_q & phase_sum_select_i[ph] &
                (active_power_neg_i[ph] ^ act_neg_q[ph]);
            assign react_sign_change[ph] = hist_valid_q & phase_sum_select_i[ph] &
                (reactive_power_neg_i[ph] ^ react_neg_q[ph]);
        end
    endgenerate

    // history of the watched bits, valid from the second cycle after reset
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hist_valid_q <= 1'b0;
            act_b14_q <= 3'h0;
            react_b14_q <= 3'h0;
            app_b15_q <= 3'h0;
            act_neg_q <= 3'h0;
            react_neg_q <= 3'h0;
        end else begin
            hist_valid_q <= 1'b1;
            act_b14_q <= active_energy_accum_b14_i;
            react_b14_q <= reactive_energy_accum_b14_i;
            app_b15_q <= apparent_energy_accum_b15_i;
            act_neg_q <= active_power_neg_i;
            react_neg_q <= reactive_power_neg_i;
        end
    end

    // phase sequence checker: after a crossing on a, wait for b or c
    always @* begin
        seq_d = seq_q;
        seq_err = 1'b0;
        case (seq_q)
            SEQ_IDLE: begin
                if (crossing_i[0]) begin
                    seq_d = SEQ_AFTER_A;
                end
            end
            SEQ_AFTER_A: begin
                if (crossing_i[2]) begin
                    seq_d = crossing_i[0] ? SEQ_AFTER_A : SEQ_IDLE;
                end else if (crossing_i[1]) begin
                    seq_err = 1'b1;
                    seq_d = crossing_i[0] ? SEQ_AFTER_A : SEQ_IDLE;
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
            end
        endcase
    end

    // sequence state register
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            seq_q <= SEQ_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    // event vector, one bit per flag
    always @* begin
        event_set = {NUM_FLAGS{1'b0}};
        event_set[`MIF_BIT_ACT_HALF] = |act_change;
        event_set[`MIF_BIT_REACT_HALF] = |react_change;
        event_set[`MIF_BIT_APP_HALF] = |app_rise;
        event_set[`MIF_BIT_SAG_A +: 3] = sag_i;
        event_set[`MIF_BIT_TMO_A +: 3] = crossing_timeout_i;
        event_set[`MIF_BIT_CROSS_A +: 3] = crossing_i;
        event_set[`MIF_BIT_LINE_DONE] = line_cycle_energy_done_i;
        event_set[`MIF_BIT_PEAK_V] = peak_voltage_i;
        event_set[`MIF_BIT_PEAK_I] = peak_current_i;
        event_set[`MIF_BIT_WAVE] = waveform_sample_ready_i;
        event_set[`MIF_BIT_ACT_SIGN] = |act_sign_change;
        event_set[`MIF_BIT_REACT_SIGN] = |react_sign_change;
        event_set[`MIF_BIT_SEQ_ERR] = seq_err;
    end

    // sticky flags: set wins over the clear-on-read
    always @* begin
        flags_d = flags_q;
        if (read_cor) begin
            flags_d = `MIF_FLAGS_RESET;
        end
        flags_d = flags_d | event_set;
    end

    // flag register
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            flags_q <= `MIF_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // reset event bit, high for the single cycle after release
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            reset_evt_q <= 1'b1;
        end else begin
            reset_evt_q <= 1'b0;
        end
    end

    // reset event placed at its own bit position
    always @* begin
        reset_evt_vec = {NUM_FLAGS{1'b0}};
        reset_evt_vec[`MIF_BIT_RESET_EVT] = reset_evt_q;
    end

    // what both flag registers show
    assign flags_view = flags_q | reset_evt_vec;

    // request flop fed from next values, so it moves with flags and enable
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_oe_q <= 1'b0;
        end else begin
            irq_oe_q <= |(flags_d & enable_d);
        end
    end

    // open-drain request, pulled low while an enabled flag is set
    assign irq_oe_o = irq_oe_q;
    assign irq_n_o = 1'b0;

    // axi write channels taken in either order
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign do_write = aw_got_q && w_got_q && !bvalid_q;
    assign wr_idx = {2'b00, awaddr_q[7:2]}; // word index of the held write

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // byte-lane mask for the enable register
    assign wr_bytes = {{4{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // next enable value: chosen lanes only, reserved bit kept clear
    always @* begin
        enable_d = enable_q;
        if (do_write && wr_idx == `MIF_IDX_ENABLE) begin
            enable_d = (enable_q & ~wr_bytes) |
                (wdata_q[NUM_FLAGS-1:0] & wr_bytes & `MIF_ENABLE_WMASK);
        end
    end

    // enable register and write response
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            enable_q <= `MIF_ENABLE_RESET;
            bvalid_q <= 1'b0;
            bresp_q <= `MIF_RESP_OKAY;
        end else begin
            enable_q <= enable_d;
            if (do_write) begin
                bvalid_q <= 1'b1;
                case (wr_idx)
                    `MIF_IDX_ENABLE: begin
                        bresp_q <= `MIF_RESP_OKAY;
                    end
                    default: begin
                        bresp_q <= `MIF_RESP_SLVERR; // read-only or unmapped
                    end
                endcase
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // write response outputs
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // axi read: one outstanding, data captured at address acceptance
    assign s_axi_arready = !rvalid_q;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign rd_idx = {2'b00, s_axi_araddr[7:2]};
    assign read_cor = do_read && (rd_idx == `MIF_IDX_FLAGS_COR);

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `MIF_RESP_OKAY;
        end else begin
            if (do_read) begin
                rvalid_q <= 1'b1;
                rresp_q <= `MIF_RESP_OKAY;
                case (rd_idx)
                    `MIF_IDX_ENABLE: begin
                        rdata_q <= {{(32-NUM_FLAGS){1'b0}}, enable_q};
                    end
                    `MIF_IDX_FLAGS: begin
                        rdata_q <= {{(32-NUM_FLAGS){1'b0}}, flags_view};
                    end
                    `MIF_IDX_FLAGS_COR: begin
                        rdata_q <= {{(32-NUM_FLAGS){1'b0}}, flags_view};
                    end
                    default: begin
                        rdata_q <= 32'h00000000;
                        rresp_q <= `MIF_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // read answer outputs
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // mif_irq

// ===== verif/mif_irq_checker.sv
`timescale 1ns/10ps
module mif_irq_checker (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // event inputs
    input wire [2:0] active_energy_accum_b14_i,
    input wire [2:0] reactive_energy_accum_b14_i,
    input wire [2:0] apparent_energy_accum_b15_i,
    input wire [2:0] sag_i,
    input wire [2:0] crossing_timeout_i,
    input wire [2:0] crossing_i,
    input wire line_cycle_energy_done_i,
    input wire peak_voltage_i,
    input wire peak_current_i,
    input wire waveform_sample_ready_i,
    input wire [2:0] active_power_neg_i,
    input wire [2:0] reactive_power_neg_i,
    // request line
    input wire irq_n_o,
    input wire irq_oe_o,
    // register bus
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid
);
    reg [14:0] lvl_q;
    reg wpend_q;
    reg cross_q;
    wire [14:0] lvl = {active_energy_accum_b14_i, reactive_energy_accum_b14_i,
        apparent_energy_accum_b15_i, active_power_neg_i, reactive_power_neg_i};
    // any event this cycle, crossings kept one more cycle for the order check
    wire ev = (|{sag_i, crossing_timeout_i, crossing_i, line_cycle_energy_done_i,
        peak_voltage_i, peak_current_i, waveform_sample_ready_i}) || lvl != lvl_q || cross_q;
    wire ar_go = s_axi_arvalid && s_axi_arready;
    wire w_go = s_axi_wvalid && s_axi_wready;
    wire cor = ar_go && s_axi_araddr == 8'h68;

    // level history and pending register write
    always @(posedge ref_clk_i) begin
        lvl_q <= lvl;
        cross_q <= |crossing_i;
        if (!rst_n_i || s_axi_bvalid)
            wpend_q <= 1'h0;
        else if (w_go)
            wpend_q <= 1'h1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_hold; irq_oe_o && !cor && !wpend_q && !w_go |=> irq_oe_o; endproperty
    a_hold: assert property (p_hold) else $error("request line dropped");
    property p_plain;
        irq_oe_o && ar_go && s_axi_araddr == 8'h64 && !wpend_q && !w_go |=> irq_oe_o;
    endproperty
    a_plain: assert property (p_plain) else $error("plain read released line");
    property p_cor; cor && !ev |=> !irq_oe_o; endproperty
    a_cor: assert property (p_cor) else $error("line kept after clearing read");
    property p_cor_data; cor && irq_oe_o |=> s_axi_rvalid && s_axi_rdata[19:0] != 20'h0; endproperty
    a_cor_data: assert property (p_cor_data) else $error("clearing read lost flags");
    property p_rise; $rose(irq_oe_o) |-> $past(ev || wpend_q || w_go); endproperty
    a_rise: assert property (p_rise) else $error("line raised without cause");
    property p_drive; irq_oe_o |-> irq_n_o == 1'h0; endproperty
    a_drive: assert property (p_drive) else $error("driven line not low");
    property p_rd_ans; ar_go |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data not held");
    property p_unmap;
        ar_go && s_axi_araddr[7:2] > 6'h1A |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");

    // main scenarios reached
    c_cor: cover property (cor && irq_oe_o);
    c_rise: cover property ($rose(irq_oe_o));
    c_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // mif_irq_checker

bind mif_irq mif_irq_checker i_chk (.*);

// ===== verif/mif_host_model.sv
`timescale 1ns/10ps
module mif_host_model (
    // device pins
    input wire irq_n_o,
    input wire irq_oe_o,
    // line level seen by the host
    output wire irq_line_o
);
    // pull-up holds the line high unless the device drives it
    assign irq_line_o = irq_oe_o ? irq_n_o : 1'h1;
endmodule // mif_host_model

// ===== verif/tb.sv
`timescale 1ns/10ps
`include "mif_defines.vh"
module tb;
    // stimulus
    reg ref_clk_i = 1'h0, rst_n_i = 1'h0;
    reg [2:0] active_energy_accum_b14_i = 3'h0, reactive_energy_accum_b14_i = 3'h0;
    reg [2:0] apparent_energy_accum_b15_i = 3'h0, sag_i = 3'h0, crossing_timeout_i = 3'h0;
    reg [2:0] crossing_i = 3'h0, active_power_neg_i = 3'h0, reactive_power_neg_i = 3'h0;
    reg [2:0] phase_sum_select_i = 3'h1;
    reg line_cycle_energy_done_i = 1'h0, peak_voltage_i = 1'h0, peak_current_i = 1'h0;
    reg waveform_sample_ready_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    reg s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, t1, t2;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0, x;
    reg [3:0] s_axi_wstrb = 4'hF;
    // design outputs
    wire irq_n_o, irq_oe_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, irq_line;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer err_total = 0, compares = 0, cyc = 0, b;

    mif_irq i_dut (.*);
    mif_host_model i_host (.irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .irq_line_o(irq_line));

    initial forever #12.5 ref_clk_i = ~ref_clk_i;

    // hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total = err_total + 1;
            print_verdict;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // bus write, response accepted late to stall the slave
    task wr(input [7:0] a, input [31:0] d, input [1:0] rsp);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            @(negedge ref_clk_i);
            while (!s_axi_bvalid) begin
                t1 = s_axi_awready;
                t2 = s_axi_wready;
                @(posedge ref_clk_i);
                if (t1) s_axi_awvalid <= 1'h0;
                if (t2) s_axi_wvalid <= 1'h0;
                @(negedge ref_clk_i);
            end
            chk(s_axi_bresp, rsp);
            @(posedge ref_clk_i);
            s_axi_bready <= 1'h1;
            @(posedge ref_clk_i);
            s_axi_bready <= 1'h0;
        end
    endtask

    // bus read, data accepted late to stall the slave
    task rd(input [7:0] a, input [31:0] exp, input [1:0] rsp);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            @(negedge ref_clk_i);
            while (!s_axi_rvalid) begin
                t1 = s_axi_arready;
                @(posedge ref_clk_i);
                if (t1) s_axi_arvalid <= 1'h0;
                @(negedge ref_clk_i);
            end
            chk(s_axi_rdata, exp);
            chk(s_axi_rresp, rsp);
            @(posedge ref_clk_i);
            s_axi_rready <= 1'h1;
            @(posedge ref_clk_i);
            s_axi_rready <= 1'h0;
        end
    endtask

    // raise the event behind flag n; 19 is a crossing on a then on b
    task fire(input integer n);
        begin
            case (n)
                0: active_energy_accum_b14_i[0] <= ~active_energy_accum_b14_i[0];
                1: reactive_energy_accum_b14_i[1] <= ~reactive_energy_accum_b14_i[1];
                2: apparent_energy_accum_b15_i[2] <= 1'h1;
                3, 4, 5: sag_i[n-3] <= 1'h1;
                6, 7, 8: crossing_timeout_i[n-6] <= 1'h1;
                9, 10, 11, 19: crossing_i[(n-9)%10] <= 1'h1;
                12: line_cycle_energy_done_i <= 1'h1;
                14: peak_voltage_i <= 1'h1;
                15: peak_current_i <= 1'h1;
                16: waveform_sample_ready_i <= 1'h1;
                17: active_power_neg_i[0] <= 1'h1;
                default: reactive_power_neg_i[0] <= 1'h1;
            endcase
            @(posedge ref_clk_i);
            {sag_i, crossing_timeout_i, line_cycle_energy_done_i, peak_voltage_i} <= 8'h00;
            {peak_current_i, waveform_sample_ready_i} <= 2'h0;
            crossing_i <= (n == 19) ? 3'h2 : 3'h0;
            @(posedge ref_clk_i);
            crossing_i <= 3'h0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask

    task line(input exp);
        begin
            @(negedge ref_clk_i);
            chk(irq_line, exp);
            @(posedge ref_clk_i);
        end
    endtask

    task print_verdict;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        rd(`MIF_ADDR_FLAGS, 32'h2000, 2'h0);
        rd(`MIF_ADDR_FLAGS_COR, 32'h0, 2'h0);
        rd(`MIF_ADDR_ENABLE, 32'h0, 2'h0);
        rd(8'h70, 32'h0, `MIF_RESP_SLVERR);
        s_axi_wstrb <= 4'h4;
        wr(`MIF_ADDR_ENABLE, 32'hFFFFFFFF, 2'h0);
        rd(`MIF_ADDR_ENABLE, 32'hF0000, 2'h0);
        s_axi_wstrb <= 4'hF;
        wr(`MIF_ADDR_FLAGS, 32'hFFFFF, `MIF_RESP_SLVERR);
        wr(`MIF_ADDR_FLAGS_COR, 32'hFFFFF, `MIF_RESP_SLVERR);
        // masked event: flag only, line stays released
        fire(3);
        line(1'h1);
        rd(`MIF_ADDR_FLAGS_COR, 32'h8, 2'h0);
        wr(`MIF_ADDR_ENABLE, 32'hFFFFFFFF, 2'h0);
        rd(`MIF_ADDR_ENABLE, {12'h000, `MIF_ENABLE_WMASK}, 2'h0);
        // every event enabled, serviced by flags read then clearing read
        for (b = 0; b < 20; b = b + 1) begin
            if (b != 13) begin
                fire(b);
                // the crossing on a of the step before makes b a sequence error too
                x = (b == 19) ? 32'h80600 : (b == 10) ? 32'h80400 : (32'h1 << b);
                line(1'h0);
                rd(`MIF_ADDR_FLAGS, x, 2'h0);
                line(1'h0);
                rd(`MIF_ADDR_FLAGS_COR, x, 2'h0);
                line(1'h1);
                rd(`MIF_ADDR_FLAGS, 32'h0, 2'h0);
            end
        end
        // falling top bit and an unselected phase raise nothing
        apparent_energy_accum_b15_i <= 3'h0;
        active_power_neg_i[1] <= 1'h1;
        repeat (3) @(posedge ref_clk_i);
        rd(`MIF_ADDR_FLAGS, 32'h0, 2'h0);
        // second reset in mid-run: reset bit shown once more, enable back to default
        rst_n_i <= 1'h0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        rd(`MIF_ADDR_FLAGS, 32'h2000, 2'h0);
        rd(`MIF_ADDR_ENABLE, 32'h0, 2'h0);
        line(1'h1);
        print_verdict;
    end
endmodule // tb
